// >>> core/camdd_core.sv
// Overview of operation
// - 16-bit ALU: add, subtract, shifts, logic
// - Arithmetic uses two's complement operands
// - ALU updates carry, zero, negative, wrap, nibble
// - Subtract: carry and nibble flags mean no-borrow
// - Byte or word size per instruction
// - Operands/results from work registers or memory
// - 17x17 multiplier extends signed or unsigned operands
// - Word, literal and byte multiply modes supported
// - Divide 32/16 and 16/16, signed and unsigned
// - Quotient to first, remainder to second register
// - Any divisor register, aligned dividend pair
// - One divide cycle per divisor bit
// - DSP multiplier, 40-bit shifter, adder, two accumulators
// - Accumulator add, subtract, negate without operands
// - Control word picks fraction, sign, rounding
// - Separate saturation enables, selectable saturation width
// - DSP ops with optional accumulator write-back
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "camdd_regs.svh"
module camdd_core
	import camdd_pkg::*;
(
	input wire logic i_clk_sys, // 250 MHz core clock
	input wire logic i_rst, // Async reset, active high
	input wire logic [3:0] i_reg_addr, // Register index
	input wire logic [15:0] i_reg_wdata, // Register write data
	input wire logic i_reg_wr, // Register write strobe
	input wire logic i_reg_rd, // Register read strobe
	output logic [15:0] o_reg_rdata, // Read data, cycle after strobe
	input wire logic i_alu_valid, // ALU op request
	input wire camdd_alu_op_t i_alu_op, // ALU operation
	input wire logic i_alu_byte, // Byte-size operation
	input wire logic i_alu_src_mem, // Operand A from memory
	input wire logic i_alu_dst_mem, // Result to memory
	input wire logic [15:0] i_w_opnd, // Operand A from work register
	input wire logic [15:0] i_mem_opnd, // Operand A from memory
	input wire logic [15:0] i_alu_b, // Operand B / shift count
	output logic o_alu_done, // ALU result pulse
	output logic [15:0] o_alu_result, // ALU result
	output logic o_alu_w_wr, // Write result to work register
	output logic o_alu_mem_wr, // Write result to memory
	output logic [4:0] o_status_word, // Flags: NIB,WRAP,NEG,ZERO,CARRY
	input wire logic i_mul_valid, // Multiply request
	input wire camdd_mul_mode_t i_mul_mode, // Multiply mode
	input wire logic [15:0] i_mul_a, // Multiplicand
	input wire logic [15:0] i_mul_b, // Multiplier or literal
	output logic o_mul_done, // Product pulse
	output logic [31:0] o_mul_prod, // Product
	input wire logic i_div_start, // Divide request
	input wire logic i_div_signed, // Signed divide
	input wire logic i_div_long, // 32-bit dividend
	input wire logic [31:0] i_div_dividend, // Register pair, odd:even
	input wire logic [15:0] i_div_divisor, // Any work register
	output logic o_div_busy, // Divider iterating
	output logic o_div_done, // Quotient and remainder valid
	output logic [15:0] o_div_w0, // Quotient, first register
	output logic [15:0] o_div_w1, // Remainder, second register
	input wire logic i_dsp_valid, // DSP op request
	input wire camdd_dsp_op_t i_dsp_op, // DSP operation
	input wire logic i_dsp_acc_sel, // Target: 0 A, 1 B
	input wire logic i_dsp_wb, // Write back other accumulator
	input wire logic signed [5:0] i_dsp_shift, // Result shift, +left
	input wire logic [15:0] i_dsp_x, // X operand
	input wire logic [15:0] i_dsp_y, // Y operand
	output logic o_dsp_done, // DSP op pulse
	output logic o_wb_valid, // Write-back pulse
	output logic [15:0] o_wb_data // Rounded write-back word
);
	logic [7:0] ccw_q;
	logic [4:0] sw_q;
	logic [39:0] accumulator_a_q;
	logic [39:0] accumulator_b_q;

	// ALU datapath
	logic [15:0] opa;
	logic [16:0] sum;
	logic [15:0] res;
	logic [15:0] bx;
	logic [3:0] sh;
	logic c_f;
	logic z_f;
	logic n_f;
	logic v_f;
	logic dc_f;
	logic arith;
	logic [16:0] shl_w;
	logic [16:0] shr_w;
	logic [15:0] shs;

	assign opa = i_alu_src_mem ? i_mem_opnd : i_w_opnd;
	assign sh = i_alu_b[3:0];
	assign shl_w = {1'b0, opa} << sh;
	assign shs = !i_alu_byte ? opa
		: {(i_alu_op == ALU_ASR && opa[7]) ? 8'hFF : 8'h00, opa[7:0]};
	assign shr_w = i_alu_op == ALU_ASR ? 17'($signed({shs, 1'b0}) >>> sh)
		: ({shs, 1'b0} >> sh);

	always_comb
	begin
		arith = (i_alu_op == ALU_ADD) || (i_alu_op == ALU_SUB);
		// Subtract as a + ~b + 1 so carry reads as no-borrow
		bx = (i_alu_op == ALU_SUB) ? ~i_alu_b : i_alu_b;
		sum = {1'b0, opa} + {1'b0, bx} + {16'h0000, i_alu_op == ALU_SUB};
		res = 16'h0000;
		c_f = sw_q[`CAMDD_SW_CARRY];
		dc_f = sw_q[`CAMDD_SW_NIBBLE];
		v_f = sw_q[`CAMDD_SW_WRAP];
		case (i_alu_op)
			ALU_ADD, ALU_SUB: res = sum[15:0];
			ALU_AND: res = opa & i_alu_b;
			ALU_IOR: res = opa | i_alu_b;
			ALU_XOR: res = opa ^ i_alu_b;
			ALU_SHL: res = shl_w[15:0];
			ALU_SHR, ALU_ASR: res = shr_w[16:1];
			default: res = 16'h0000;
		endcase
		if (i_alu_byte)
			res = {8'h00, res[7:0]};
		if (arith)
		begin
			if (i_alu_byte)
			begin
				c_f = opa[8] ^ bx[8] ^ sum[8];
				v_f = (opa[7] == bx[7]) && (res[7] != opa[7]);
			end
			else
			begin
				c_f = sum[16];
				v_f = (opa[15] == bx[15]) && (res[15] != opa[15]);
			end
			dc_f = opa[4] ^ bx[4] ^ sum[4];
		end
		else if (i_alu_op == ALU_SHL && sh != 4'h0)
			c_f = i_alu_byte ? shl_w[8] : shl_w[16];
		else if ((i_alu_op == ALU_SHR || i_alu_op == ALU_ASR) && sh != 4'h0)
			c_f = shr_w[0];
		z_f = i_alu_byte ? (res[7:0] == 8'h00) : (res == 16'h0000);
		n_f = i_alu_byte ? res[7] : res[15];
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			sw_q <= `CAMDD_SW_RESET;
			o_alu_done <= 1'b0;
			o_alu_result <= 16'h0000;
			o_alu_w_wr <= 1'b0;
			o_alu_mem_wr <= 1'b0;
		end
		else
		begin
			o_alu_done <= i_alu_valid;
			o_alu_w_wr <= i_alu_valid && !i_alu_dst_mem;
			o_alu_mem_wr <= i_alu_valid && i_alu_dst_mem;
			if (i_alu_valid)
			begin
				o_alu_result <= res;
				sw_q <= {dc_f, v_f, n_f, z_f, c_f};
			end
		end
	end

	// Integer multiplier on 17-bit extended operands
	logic [16:0] ma;
	logic [16:0] mb;
	logic [33:0] mprod;

	always_comb
	begin
		ma = {i_mul_a[15], i_mul_a};
		mb = {i_mul_b[15], i_mul_b};
		case (i_mul_mode)
			MUL_SS: ;
			MUL_UU: {ma, mb} = {1'b0, i_mul_a, 1'b0, i_mul_b};
			MUL_SU: mb = {1'b0, i_mul_b};
			MUL_US: ma = {1'b0, i_mul_a};
			MUL_S_LIT: mb = {12'h000, i_mul_b[4:0]};
			MUL_U_LIT: {ma, mb} = {1'b0, i_mul_a, 12'h000, i_mul_b[4:0]};
			MUL_BYTE_UU: {ma, mb} = {9'h000, i_mul_a[7:0], 9'h000, i_mul_b[7:0]};
			default: ;
		endcase
		mprod = 34'($signed(ma) * $signed(mb));
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_mul_done <= 1'b0;
			o_mul_prod <= 32'h00000000;
		end
		else
		begin
			o_mul_done <= i_mul_valid;
			if (i_mul_valid)
				o_mul_prod <= mprod[31:0];
		end
	end

	// Divider: 16-bit dividend extended to the common 32-bit path
	logic [31:0] dvd;
	logic [15:0] sgn_hi;

	assign sgn_hi = {16{i_div_signed & i_div_dividend[15]}};
	assign dvd = i_div_long ? i_div_dividend : {sgn_hi, i_div_dividend[15:0]};

	camdd_divider #(
		.DW(16)
	) u_div (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_start(i_div_start),
		.i_signed(i_div_signed),
		.i_dividend(dvd),
		.i_divisor(i_div_divisor),
		.o_busy(o_div_busy),
		.o_done(o_div_done),
		.o_quot(o_div_w0),
		.o_rem(o_div_w1)
	);

	// DSP engine
	logic [39:0] acc_t;
	logic [39:0] acc_o;
	logic [16:0] dx;
	logic [16:0] dy;
	logic [16:0] diff;
	logic [33:0] dprod;
	logic [40:0] p41;
	logic [40:0] s41;
	logic [39:0] shv;
	logic sat_en;
	logic wb_op;

	function automatic logic [39:0] sat40(input logic [40:0] s, input logic en, input logic w40);
		logic [39:0] r;
		r = s[39:0];
		if (en && w40 && (s[40] != s[39]))
			r = s[40] ? 40'h8000000000 : 40'h7FFFFFFFFF;
		else if (en && !w40 && (s[40:31] != {10{s[40]}}))
			r = s[40] ? 40'hFF80000000 : 40'h007FFFFFFF;
		return r;
	endfunction

	function automatic logic [15:0] rnd16(input logic [39:0] a, input logic conv, input logic st);
		logic [24:0] u;
		logic inc;
		inc = a[15];
		if (conv && a[15:0] == 16'h8000)
			inc = a[16]; // Ties round to even
		u = 25'($signed(a[39:16])) + {24'h000000, inc};
		rnd16 = u[15:0];
		if (st && (u[24:15] != {10{u[24]}}))
			rnd16 = u[24] ? 16'h8000 : 16'h7FFF;
	endfunction

	always_comb
	begin
		acc_t = i_dsp_acc_sel ? accumulator_b_q : accumulator_a_q;
		acc_o = i_dsp_acc_sel ? accumulator_a_q : accumulator_b_q;
		sat_en = i_dsp_acc_sel ? ccw_q[`CAMDD_CCW_SAT_B] : ccw_q[`CAMDD_CCW_SAT_A];
		diff = 17'($signed({i_dsp_x[15], i_dsp_x}) - $signed({i_dsp_y[15], i_dsp_y}));
		dx = {i_dsp_x[15], i_dsp_x};
		dy = {i_dsp_y[15], i_dsp_y};
		case (ccw_q[`CAMDD_CCW_SIGN_HI:`CAMDD_CCW_SIGN_LO])
			2'h1: {dx, dy} = {1'b0, i_dsp_x, 1'b0, i_dsp_y};
			2'h2: dy = {1'b0, i_dsp_y};
			default: ;
		endcase
		if (i_dsp_op == DSP_SQ_DIFF || i_dsp_op == DSP_SQ_DIFF_ACCUM)
			{dx, dy} = {diff, diff};
		else if (i_dsp_op == DSP_SQ_ACCUM || i_dsp_op == DSP_SQ)
			dy = dx;
		dprod = 34'($signed(dx) * $signed(dy));
		p41 = 41'($signed(dprod));
		if (!ccw_q[`CAMDD_CCW_FRAC_INT])
			p41 = {p41[39:0], 1'b0};
		case (i_dsp_op)
			DSP_ACC_ZERO: s41 = 41'h00000000000;
			DSP_SQ_DIFF, DSP_MULT, DSP_SQ: s41 = p41;
			DSP_NEG_MULT: s41 = -p41;
			DSP_SQ_DIFF_ACCUM, DSP_MULT_ACCUM, DSP_SQ_ACCUM: s41 = {acc_t[39], acc_t} + p41;
			DSP_MULT_SUB: s41 = {acc_t[39], acc_t} - p41;
			DSP_ACC_ADD: s41 = {acc_t[39], acc_t} + {acc_o[39], acc_o};
			DSP_ACC_SUB: s41 = {acc_t[39], acc_t} - {acc_o[39], acc_o};
			DSP_ACC_NEG: s41 = -{acc_t[39], acc_t};
			DSP_PREFETCH_MOVE: s41 = {acc_t[39], acc_t};
			default: s41 = {acc_t[39], acc_t};
		endcase
		shv = sat40(s41, sat_en, ccw_q[`CAMDD_CCW_SAT_WIDTH]);
		// Barrel shift of the 40-bit result
		if (i_dsp_shift < 0)
			shv = 40'($signed(shv) >>> (-i_dsp_shift));
		else
			shv = shv << i_dsp_shift;
		wb_op = (i_dsp_op == DSP_ACC_ZERO) || (i_dsp_op == DSP_MULT_ACCUM)
			|| (i_dsp_op == DSP_PREFETCH_MOVE) || (i_dsp_op == DSP_MULT_SUB);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			accumulator_a_q <= 40'h0000000000;
			accumulator_b_q <= 40'h0000000000;
			o_dsp_done <= 1'b0;
			o_wb_valid <= 1'b0;
			o_wb_data <= 16'h0000;
		end
		else
		begin
			o_dsp_done <= i_dsp_valid;
			o_wb_valid <= i_dsp_valid && i_dsp_wb && wb_op;
			if (i_dsp_valid && i_dsp_wb && wb_op)
				o_wb_data <= rnd16(acc_o, ccw_q[`CAMDD_CCW_ROUND], ccw_q[`CAMDD_CCW_SAT_MEM]);
			if (i_dsp_valid && !i_dsp_acc_sel)
				accumulator_a_q <= shv;
			if (i_dsp_valid && i_dsp_acc_sel)
				accumulator_b_q <= shv;
		end
	end

	// Register port
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			ccw_q <= `CAMDD_CCW_RESET;
		else if (i_reg_wr && i_reg_addr == `CAMDD_ADDR_CORE_CTRL)
			ccw_q <= i_reg_wdata[7:0];
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			o_reg_rdata <= 16'h0000;
		else if (i_reg_rd)
		begin
			case (i_reg_addr)
				`CAMDD_ADDR_CORE_CTRL: o_reg_rdata <= {8'h00, ccw_q};
				`CAMDD_ADDR_STATUS: o_reg_rdata <= {11'h000, sw_q};
				`CAMDD_ADDR_ACCUMULATOR_A_LO: o_reg_rdata <= accumulator_a_q[15:0];
				`CAMDD_ADDR_ACCUMULATOR_A_HI: o_reg_rdata <= accumulator_a_q[31:16];
				`CAMDD_ADDR_ACCUMULATOR_A_UP: o_reg_rdata <= {8'h00, accumulator_a_q[39:32]};
				`CAMDD_ADDR_ACCUMULATOR_B_LO: o_reg_rdata <= accumulator_b_q[15:0];
				`CAMDD_ADDR_ACCUMULATOR_B_HI: o_reg_rdata <= accumulator_b_q[31:16];
				`CAMDD_ADDR_ACCUMULATOR_B_UP: o_reg_rdata <= {8'h00, accumulator_b_q[39:32]};
				default: o_reg_rdata <= 16'h0000;
			endcase
		end
		else
			o_reg_rdata <= 16'h0000;
	end

	assign o_status_word = sw_q;
endmodule

// >>> core/camdd_regs.svh
`ifndef CAMDD_REGS_SVH
`define CAMDD_REGS_SVH
// Register indices on the plain register port
`define CAMDD_ADDR_CORE_CTRL 4'h0
`define CAMDD_ADDR_STATUS 4'h1
`define CAMDD_ADDR_ACCUMULATOR_A_LO 4'h2
`define CAMDD_ADDR_ACCUMULATOR_A_HI 4'h3
`define CAMDD_ADDR_ACCUMULATOR_A_UP 4'h4
`define CAMDD_ADDR_ACCUMULATOR_B_LO 4'h5
`define CAMDD_ADDR_ACCUMULATOR_B_HI 4'h6
`define CAMDD_ADDR_ACCUMULATOR_B_UP 4'h7
// core_control_word fields
`define CAMDD_CCW_FRAC_INT 0
`define CAMDD_CCW_SIGN_LO 1
`define CAMDD_CCW_SIGN_HI 2
`define CAMDD_CCW_ROUND 3
`define CAMDD_CCW_SAT_A 4
`define CAMDD_CCW_SAT_B 5
`define CAMDD_CCW_SAT_MEM 6
`define CAMDD_CCW_SAT_WIDTH 7
`define CAMDD_CCW_RESET 8'h00
// status_word fields
`define CAMDD_SW_CARRY 0
`define CAMDD_SW_ZERO 1
`define CAMDD_SW_NEG 2
`define CAMDD_SW_WRAP 3
`define CAMDD_SW_NIBBLE 4
`define CAMDD_SW_RESET 5'h00
// Divider iterations, one per divisor bit
`define CAMDD_DIV_CYCLES 16
`endif

// >>> core/camdd_pkg.sv
package camdd_pkg;
	typedef enum logic [2:0]
	{
		ALU_ADD = 3'h0,
		ALU_SUB = 3'h1,
		ALU_AND = 3'h2,
		ALU_IOR = 3'h3,
		ALU_XOR = 3'h4,
		ALU_SHL = 3'h5,
		ALU_SHR = 3'h6,
		ALU_ASR = 3'h7
	} camdd_alu_op_t;

	typedef enum logic [2:0]
	{
		MUL_SS = 3'h0,
		MUL_UU = 3'h1,
		MUL_SU = 3'h2,
		MUL_US = 3'h3,
		MUL_S_LIT = 3'h4,
		MUL_U_LIT = 3'h5,
		MUL_BYTE_UU = 3'h6
	} camdd_mul_mode_t;

	typedef enum logic [3:0]
	{
		DSP_ACC_ZERO = 4'h0,
		DSP_SQ_DIFF = 4'h1,
		DSP_SQ_DIFF_ACCUM = 4'h2,
		DSP_MULT_ACCUM = 4'h3,
		DSP_SQ_ACCUM = 4'h4,
		DSP_PREFETCH_MOVE = 4'h5,
		DSP_MULT = 4'h6,
		DSP_SQ = 4'h7,
		DSP_NEG_MULT = 4'h8,
		DSP_MULT_SUB = 4'h9,
		DSP_ACC_ADD = 4'hA,
		DSP_ACC_SUB = 4'hB,
		DSP_ACC_NEG = 4'hC
	} camdd_dsp_op_t;

	typedef enum logic [0:0]
	{
		DIV_IDLE = 1'b0,
		DIV_RUN = 1'b1
	} camdd_div_state_t;
endpackage

// >>> core/camdd_divider.sv
`timescale 1ns/1ps
`include "camdd_regs.svh"
module camdd_divider
	import camdd_pkg::*;
#(
	parameter int DW = 16
)
(
	input wire logic i_clk_sys, // Core clock
	input wire logic i_rst, // Async reset
	input wire logic i_start, // Start pulse
	input wire logic i_signed, // Signed divide
	input wire logic [2*DW-1:0] i_dividend, // Extended dividend
	input wire logic [DW-1:0] i_divisor, // Divisor
	output logic o_busy, // Iterating
	output logic o_done, // Result valid pulse
	output logic [DW-1:0] o_quot, // Quotient
	output logic [DW-1:0] o_rem // Remainder
);
	localparam logic [5:0] LAST = 6'(`CAMDD_DIV_CYCLES - 1);

	camdd_div_state_t state_q;
	logic [DW:0] rem_q;
	logic [DW-1:0] quo_q;
	logic [DW-1:0] dsr_q;
	logic [5:0] cnt_q;
	logic neg_q_q;
	logic neg_r_q;
	logic [DW:0] trial;
	logic fits;
	logic [2*DW-1:0] dvd_mag;

	if (DW != `CAMDD_DIV_CYCLES)
	begin : g_chk
		$error("camdd_divider: DW must equal the iteration count");
	end

	assign dvd_mag = (i_signed && i_dividend[2*DW-1]) ? -i_dividend : i_dividend;
	assign trial = {rem_q[DW-1:0], quo_q[DW-1]};
	assign fits = trial >= {1'b0, dsr_q};

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q <= DIV_IDLE;
			rem_q <= '0;
			quo_q <= '0;
			dsr_q <= '0;
			cnt_q <= 6'h00;
			neg_q_q <= 1'b0;
			neg_r_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				DIV_IDLE:
				begin
					if (i_start)
					begin
						rem_q <= {1'b0, dvd_mag[2*DW-1:DW]};
						quo_q <= dvd_mag[DW-1:0];
						dsr_q <= (i_signed && i_divisor[DW-1]) ? -i_divisor : i_divisor;
						neg_q_q <= i_signed && (i_dividend[2*DW-1] ^ i_divisor[DW-1]);
						neg_r_q <= i_signed && i_dividend[2*DW-1];
						cnt_q <= 6'h00;
						state_q <= DIV_RUN;
					end
				end
				DIV_RUN:
				begin
					// One quotient bit per cycle
					rem_q <= fits ? trial - {1'b0, dsr_q} : trial;
					quo_q <= {quo_q[DW-2:0], fits};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == LAST)
					begin
						state_q <= DIV_IDLE;
					end
				end
				default:
				begin
					state_q <= DIV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_done <= 1'b0;
			o_busy <= 1'b0;
			o_quot <= '0;
			o_rem <= '0;
		end
		else
		begin
			o_busy <= (state_q == DIV_IDLE) ? i_start : (cnt_q != LAST);
			o_done <= 1'b0;
			if (state_q == DIV_RUN && cnt_q == LAST)
			begin
				o_done <= 1'b1;
				o_quot <= neg_q_q ? -{quo_q[DW-2:0], fits} : {quo_q[DW-2:0], fits};
				o_rem <= neg_r_q ? -(fits ? trial[DW-1:0] - dsr_q : trial[DW-1:0])
					: (fits ? trial[DW-1:0] - dsr_q : trial[DW-1:0]);
			end
		end
	end
endmodule

// >>> dv/camdd_wreg_model.sv
`timescale 1ns/1ps
module camdd_wreg_model
(
	input wire logic i_clk_sys, // Clock
	input wire logic i_rst, // Reset
	input wire logic i_div_done, // Divide done
	input wire logic [15:0] i_quot, // Quotient
	input wire logic [15:0] i_rem, // Remainder
	output logic [15:0] o_w0, // First register
	output logic [15:0] o_w1 // Second register
);
	// Working registers take the divider results on its done pulse
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_w0 <= 16'h0000;
			o_w1 <= 16'h0000;
		end
		else if (i_div_done)
		begin
			o_w0 <= i_quot;
			o_w1 <= i_rem;
		end
	end
endmodule

// >>> dv/camdd_core_sva.sv
`timescale 1ns/1ps
module camdd_core_sva
	import camdd_pkg::*;
(
	input wire logic i_clk_sys, // Clock
	input wire logic i_rst, // Reset
	input wire logic [3:0] i_reg_addr, // Index
	input wire logic i_reg_rd, // Read
	input wire logic [15:0] o_reg_rdata, // Read data
	input wire logic i_alu_valid, // ALU request
	input wire logic i_alu_byte, // Byte size
	input wire logic i_alu_dst_mem, // To memory
	input wire logic o_alu_done, // ALU done
	input wire logic [15:0] o_alu_result, // Result
	input wire logic o_alu_w_wr, // Register write
	input wire logic o_alu_mem_wr, // Memory write
	input wire logic [4:0] o_status_word, // Flags
	input wire logic i_div_start, // Divide request
	input wire logic o_div_busy, // Divide busy
	input wire logic o_div_done, // Divide done
	input wire logic i_dsp_valid, // DSP request
	input wire camdd_dsp_op_t i_dsp_op, // DSP op
	input wire logic i_dsp_wb, // Write-back
	input wire logic o_wb_valid // Write-back pulse
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	AST_ALU_IDLE: assert property (!i_alu_valid |=> !o_alu_done && !o_alu_w_wr && !o_alu_mem_wr)
		else $error("ALU pulse without request");
	AST_ALU_DEST: assert property (i_alu_valid |=> o_alu_done &&
		o_alu_mem_wr == $past(i_alu_dst_mem) && o_alu_w_wr != $past(i_alu_dst_mem))
		else $error("ALU result routed wrongly");
	AST_BYTE_HI: assert property (i_alu_valid && i_alu_byte |=> o_alu_result[15:8] == 8'h00)
		else $error("Byte result upper half not clear");
	AST_ZERO_FLAG: assert property (o_alu_done |-> o_status_word[1] == (o_alu_result == 16'h0000))
		else $error("Zero flag disagrees with result");
	AST_DIV_LAT: assert property (i_div_start && !o_div_busy |-> ##17 o_div_done)
		else $error("Divide not done after 16 iterations");
	AST_DIV_DONE: assert property (o_div_done |-> !o_div_busy && $past(o_div_busy))
		else $error("Divide done out of sequence");
	AST_STATUS_RD: assert property (i_reg_rd && i_reg_addr == 4'h1 |=>
		o_reg_rdata == {11'h000, $past(o_status_word)})
		else $error("Status read mismatch");
	AST_WB: assert property (i_dsp_valid && i_dsp_wb && i_dsp_op inside
		{DSP_ACC_ZERO, DSP_MULT_ACCUM, DSP_PREFETCH_MOVE, DSP_MULT_SUB} |=> o_wb_valid)
		else $error("Write-back pulse missing");
endmodule
bind camdd_core camdd_core_sva u_sva (.*);

// >>> dv/camdd_core_bench.sv
`timescale 1ns/1ps
module camdd_core_bench;
	import camdd_pkg::*;
	logic i_clk_sys, i_rst, i_reg_wr, i_reg_rd, i_alu_valid, i_alu_byte, i_alu_src_mem;
	logic i_alu_dst_mem, i_mul_valid, i_div_start, i_div_signed, i_div_long, i_dsp_valid;
	logic i_dsp_acc_sel, i_dsp_wb, o_alu_done, o_alu_w_wr, o_alu_mem_wr, o_mul_done;
	logic o_div_busy, o_div_done, o_dsp_done, o_wb_valid;
	logic [3:0] i_reg_addr;
	logic [4:0] o_status_word;
	logic [15:0] i_reg_wdata, i_w_opnd, i_mem_opnd, i_alu_b, i_mul_a, i_mul_b, i_div_divisor;
	logic [15:0] i_dsp_x, i_dsp_y, o_reg_rdata, o_alu_result, o_div_w0, o_div_w1, o_wb_data;
	logic [15:0] w0, w1;
	logic [31:0] i_div_dividend, o_mul_prod;
	logic signed [5:0] i_dsp_shift;
	camdd_alu_op_t i_alu_op;
	camdd_mul_mode_t i_mul_mode;
	camdd_dsp_op_t i_dsp_op;
	int n_errors, checked;
	camdd_core DUT (.*);
	camdd_wreg_model u_wregs (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_div_done(o_div_done),
		.i_quot(o_div_w0), .i_rem(o_div_w1), .o_w0(w0), .o_w1(w1));
	initial
	begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	task tick;
		@(posedge i_clk_sys);
	endtask
	task chk(input logic [39:0] g, input logic [39:0] e);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task test_done;
		$display("errors=%0d checked=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Reads compare against d, writes send d
	task reg_op(input logic w, input logic [3:0] a, input logic [15:0] d);
		tick;
		{i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, !w, a, d};
		tick;
		{i_reg_wr, i_reg_rd} <= 2'b00;
		#1;
		if (!w)
			chk(o_reg_rdata, d);
	endtask
	task alu(input camdd_alu_op_t op, input logic y, s, m, input logic [15:0] a, b, r,
		input logic [4:0] f);
		tick;
		i_alu_op <= op;
		{i_alu_valid, i_alu_byte, i_alu_src_mem, i_alu_dst_mem, i_alu_b} <= {1'b1, y, s, m, b};
		{i_w_opnd, i_mem_opnd} <= s ? {~a, a} : {a, ~a};
		tick;
		i_alu_valid <= 1'b0;
		#1;
		chk(o_alu_result, r);
		chk(o_status_word, f);
		chk({o_alu_done, o_alu_mem_wr, o_alu_w_wr}, {1'b1, m, !m});
	endtask
	task mul(input camdd_mul_mode_t md, input logic [15:0] a, b, input logic [31:0] p);
		tick;
		i_mul_mode <= md;
		{i_mul_valid, i_mul_a, i_mul_b} <= {1'b1, a, b};
		tick;
		i_mul_valid <= 1'b0;
		#1;
		chk({o_mul_done, o_mul_prod}, {1'b1, p});
	endtask
	// A second start while busy must be ignored
	task div(input logic s, l, input logic [31:0] dd, input logic [15:0] dv, q, r);
		tick;
		{i_div_start, i_div_signed, i_div_long, i_div_dividend, i_div_divisor} <= {1'b1, s, l, dd, dv};
		tick;
		i_div_start <= 1'b0;
		repeat (4) tick;
		{i_div_start, i_div_divisor} <= {1'b1, 16'h0001};
		tick;
		i_div_start <= 1'b0;
		repeat (10) tick;
		#1;
		chk(o_div_busy, 1'b1);
		tick;
		#1;
		chk({o_div_done, o_div_busy, o_div_w1, o_div_w0}, {2'b10, r, q});
		tick;
		#1;
		chk({w1, w0}, {r, q});
	endtask
	task dsp(input camdd_dsp_op_t op, input logic t, w, input logic [15:0] x, y, input logic e);
		tick;
		i_dsp_op <= op;
		{i_dsp_valid, i_dsp_acc_sel, i_dsp_wb, i_dsp_x, i_dsp_y} <= {1'b1, t, w, x, y};
		tick;
		i_dsp_valid <= 1'b0;
		#1;
		chk({o_dsp_done, o_wb_valid}, {1'b1, e});
	endtask
	initial
	begin
		repeat (3000) tick;
		n_errors++;
		test_done;
	end
	initial
	begin
		{i_reg_wr, i_reg_rd, i_alu_valid, i_alu_byte, i_alu_src_mem, i_alu_dst_mem} = '0;
		{i_mul_valid, i_div_start, i_div_signed, i_div_long, i_dsp_valid, i_dsp_acc_sel} = '0;
		{i_dsp_wb, i_reg_addr, i_reg_wdata, i_w_opnd, i_mem_opnd, i_alu_b, i_mul_a} = '0;
		{i_mul_b, i_div_divisor, i_dsp_x, i_dsp_y, i_div_dividend, i_dsp_shift} = '0;
		i_alu_op = ALU_ADD;
		i_mul_mode = MUL_SS;
		i_dsp_op = DSP_ACC_ZERO;
		n_errors = 0;
		checked = 0;
		i_rst = 1'b1;
		repeat (8) tick;
		i_rst <= 1'b0;
		reg_op(1'b0, 4'h0, 16'h0000);
		reg_op(1'b0, 4'h1, 16'h0000);
		reg_op(1'b0, 4'h8, 16'h0000);
		reg_op(1'b1, 4'h0, 16'hFFFF);
		reg_op(1'b0, 4'h0, 16'h00FF);
		alu(ALU_ADD, 1'b0, 1'b0, 1'b0, 16'h7FFF, 16'h0001, 16'h8000, 5'h1C);
		alu(ALU_SUB, 1'b0, 1'b1, 1'b1, 16'h8000, 16'h0001, 16'h7FFF, 5'h09);
		alu(ALU_SUB, 1'b0, 1'b0, 1'b1, 16'h0005, 16'h0005, 16'h0000, 5'h13);
		alu(ALU_IOR, 1'b0, 1'b1, 1'b0, 16'h8000, 16'h0001, 16'h8001, 5'h15);
		alu(ALU_SUB, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0001, 16'hFFFF, 5'h04);
		alu(ALU_AND, 1'b0, 1'b0, 1'b0, 16'hF0F0, 16'h0F0F, 16'h0000, 5'h02);
		alu(ALU_XOR, 1'b0, 1'b1, 1'b0, 16'h00FF, 16'hFF00, 16'hFFFF, 5'h04);
		alu(ALU_SHL, 1'b0, 1'b0, 1'b0, 16'h8001, 16'h0001, 16'h0002, 5'h01);
		alu(ALU_SHR, 1'b0, 1'b0, 1'b0, 16'h0002, 16'h0001, 16'h0001, 5'h00);
		alu(ALU_ASR, 1'b0, 1'b0, 1'b0, 16'h8000, 16'hFFF4, 16'hF800, 5'h04);
		alu(ALU_ADD, 1'b1, 1'b1, 1'b0, 16'h12FF, 16'h3401, 16'h0000, 5'h13);
		alu(ALU_SUB, 1'b1, 1'b0, 1'b1, 16'h0080, 16'h0001, 16'h007F, 5'h09);
		reg_op(1'b1, 4'h1, 16'hFFFF);
		reg_op(1'b0, 4'h1, 16'h0009);
		alu(ALU_ASR, 1'b1, 1'b0, 1'b0, 16'h1280, 16'h0001, 16'h00C0, 5'h0C);
		mul(MUL_SS, 16'hFFFF, 16'h0002, 32'hFFFFFFFE);
		mul(MUL_UU, 16'hFFFF, 16'h0002, 32'h0001FFFE);
		mul(MUL_SU, 16'hFFFF, 16'hFFFF, 32'hFFFF0001);
		mul(MUL_US, 16'h0003, 16'hFFFF, 32'hFFFFFFFD);
		mul(MUL_S_LIT, 16'hFFFE, 16'hFFFF, 32'hFFFFFFC2);
		mul(MUL_U_LIT, 16'hFFFE, 16'hFFFF, 32'h001EFFC2);
		mul(MUL_BYTE_UU, 16'h12FF, 16'h34FF, 32'h0000FE01);
		div(1'b0, 1'b1, 32'h00010000, 16'h0002, 16'h8000, 16'h0000);
		div(1'b1, 1'b1, 32'hFFFFFFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
		div(1'b1, 1'b0, 32'hABCDFFF9, 16'hFFFE, 16'h0003, 16'hFFFF);
		div(1'b0, 1'b0, 32'h1234FFF9, 16'h0002, 16'h7FFC, 16'h0001);
		reg_op(1'b1, 4'h0, 16'h0001);
		dsp(DSP_MULT, 1'b0, 1'b0, 16'h0003, 16'h0005, 1'b0);
		dsp(DSP_MULT_ACCUM, 1'b0, 1'b1, 16'h0002, 16'h0004, 1'b1);
		dsp(DSP_SQ, 1'b1, 1'b1, 16'h0004, 16'h0000, 1'b0);
		dsp(DSP_ACC_ADD, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0);
		reg_op(1'b0, 4'h2, 16'h0027);
		dsp(DSP_ACC_SUB, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0);
		reg_op(1'b0, 4'h6, 16'hFFFF);
		dsp(DSP_ACC_NEG, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0);
		reg_op(1'b0, 4'h5, 16'h0017);
		dsp(DSP_NEG_MULT, 1'b0, 1'b0, 16'h0002, 16'h0003, 1'b0);
		dsp(DSP_MULT_SUB, 1'b0, 1'b1, 16'h0001, 16'h0002, 1'b1);
		dsp(DSP_SQ_DIFF, 1'b1, 1'b0, 16'h0007, 16'h0004, 1'b0);
		dsp(DSP_SQ_DIFF_ACCUM, 1'b1, 1'b0, 16'h0005, 16'h0003, 1'b0);
		dsp(DSP_SQ_ACCUM, 1'b0, 1'b0, 16'h0003, 16'h0000, 1'b0);
		reg_op(1'b0, 4'h2, 16'h0001);
		reg_op(1'b0, 4'h5, 16'h000D);
		dsp(DSP_ACC_ZERO, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b1);
		reg_op(1'b0, 4'h5, 16'h0000);
		reg_op(1'b1, 4'h0, 16'h0000);
		dsp(DSP_MULT, 1'b0, 1'b0, 16'h0003, 16'h0005, 1'b0);
		reg_op(1'b0, 4'h2, 16'h001E);
		reg_op(1'b1, 4'h0, 16'h0003);
		dsp(DSP_MULT, 1'b1, 1'b0, 16'hFFFF, 16'h0002, 1'b0);
		reg_op(1'b0, 4'h6, 16'h0001);
		dsp(DSP_PREFETCH_MOVE, 1'b0, 1'b1, 16'h0000, 16'h0000, 1'b1);
		chk(o_wb_data, 16'h0002);
		reg_op(1'b0, 4'h2, 16'h001E);
		reg_op(1'b1, 4'h0, 16'h0011);
		dsp(DSP_MULT, 1'b0, 1'b0, 16'h8000, 16'h8000, 1'b0);
		dsp(DSP_MULT_ACCUM, 1'b0, 1'b0, 16'h8000, 16'h8000, 1'b0);
		reg_op(1'b0, 4'h3, 16'h7FFF);
		reg_op(1'b1, 4'h0, 16'h00D1);
		dsp(DSP_MULT_ACCUM, 1'b0, 1'b0, 16'h8000, 16'h8000, 1'b0);
		reg_op(1'b0, 4'h3, 16'hBFFF);
		dsp(DSP_PREFETCH_MOVE, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b1);
		chk(o_wb_data, 16'h7FFF);
		reg_op(1'b1, 4'h0, 16'h000B);
		dsp(DSP_MULT, 1'b1, 1'b0, 16'h0005, 16'h8000, 1'b0);
		dsp(DSP_PREFETCH_MOVE, 1'b0, 1'b1, 16'h0000, 16'h0000, 1'b1);
		chk(o_wb_data, 16'h0002);
		tick;
		i_dsp_shift <= 6'h3E;
		dsp(DSP_PREFETCH_MOVE, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0);
		reg_op(1'b0, 4'h5, 16'hA000);
		test_done;
	end
endmodule
